// ---- shared/stl_cfg.svh ----
// Constants of the trigger and I/O loopback self-test
`ifndef STL_CFG_SVH
`define STL_CFG_SVH
`define STL_NUM_TESTS 23
`define STL_T_DIGIN 5'h04
`define STL_T_HSHK 5'h05
`define STL_T_DATA 5'h06
`define STL_T_TBUS 5'h07
`define STL_T_XTRIG 5'h0d
`define STL_T_GET 5'h0e
`define STL_T_SHORT 5'h0f
`define STL_T_LAST 5'h16
`define STL_CLK_NS 10
`define STL_SETTLE_NS 80
`define STL_TIMEOUT_NS 2000
`define STL_SETTLE_CYC ((`STL_SETTLE_NS + `STL_CLK_NS - 1) / `STL_CLK_NS)
`define STL_TIMEOUT_CYC (`STL_TIMEOUT_NS / `STL_CLK_NS)
`endif

// ---- shared/stl_pkg.sv ----
// Types of the trigger and I/O loopback self-test
`default_nettype none
package stl_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_APPLY = 4'h2,
		ST_WAIT = 4'h4,
		ST_EVAL = 4'h8
	} stl_state_e;
	typedef enum logic [2:0] {
		K_OUT, K_DIGIN, K_HSHK, K_DATA, K_TBUS, K_XTRIG, K_GET, K_SHORT
	} stl_kind_e;
endpackage
`default_nettype wire

// ---- rtl/stl_selftest.sv ----
// Self-test sequencer for digital I/O, bus handshake and trigger loopbacks
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"
module stl_selftest
	import stl_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = `STL_SETTLE_CYC,
	parameter int unsigned TIMEOUT_CYC = `STL_TIMEOUT_CYC
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic [3:0] user_dig_out,
	input wire logic [6:0] user_trig_drive,
	input wire logic [3:0] port_a_line_i,
	output logic [3:0] port_a_line_o_r,
	output logic [3:0] port_a_line_oe_n_r,
	output logic [3:0] oc_output_o_r,
	output logic [3:0] oc_output_oe_n_r,
	input wire logic dig_in_port_line,
	output logic dig_in_level_r,
	input wire logic buffered_not_ready_for_data,
	input wire logic buffered_not_data_accepted,
	output logic buffered_data_valid_r,
	output logic bus_dio1_o_r,
	output logic bus_dio1_oe_n_r,
	input wire logic bus_data_sense_line,
	output logic [6:0] trig_drive_all_r,
	input wire logic [7:0] trig_in_all,
	output logic get_req_r,
	output logic test_busy_r,
	output logic test_done_r,
	output logic [`STL_NUM_TESTS-1:0] test_pass_r,
	output logic [`STL_NUM_TESTS-1:0] test_fail_r
);

	localparam logic [15:0] SETTLE_W = 16'(SETTLE_CYC);
	localparam logic [15:0] TIMEOUT_W = 16'(TIMEOUT_CYC);

	// Kind of subtest from its index
	function automatic stl_kind_e kind_of(input logic [4:0] i);
		if (i < `STL_T_DIGIN) return K_OUT;
		if (i == `STL_T_DIGIN) return K_DIGIN;
		if (i == `STL_T_HSHK) return K_HSHK;
		if (i == `STL_T_DATA) return K_DATA;
		if (i < `STL_T_XTRIG) return K_TBUS;
		if (i == `STL_T_XTRIG) return K_XTRIG;
		if (i == `STL_T_GET) return K_GET;
		return K_SHORT;
	endfunction

	// Trigger input watched by a subtest, numbered from zero
	function automatic logic [2:0] sel_of(input logic [4:0] i);
		logic [4:0] d;
		d = 5'h00;
		unique case (kind_of(i))
			K_TBUS: d = i - `STL_T_TBUS;
			K_XTRIG: d = 5'h06;
			K_GET: d = 5'h07;
			K_SHORT: d = i - `STL_T_SHORT;
			default: d = 5'h00;
		endcase
		return d[2:0];
	endfunction

	stl_state_e st_r, st_nxt;
	logic [4:0] idx_r, idx_nxt;
	logic ph_r, ph_nxt;
	logic [2:0] src_r, src_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic ok_r, ok_nxt;
	logic det_r, det_nxt;
	logic [3:0] pa_o_nxt, pa_oe_n_nxt;
	logic dav_nxt, dio_oe_n_nxt, get_nxt, busy_nxt, done_nxt;
	logic [6:0] trig_nxt;
	logic [`STL_NUM_TESTS-1:0] pass_nxt, fail_nxt;
	stl_kind_e kind;
	logic [2:0] sel;
	logic [1:0] k;
	logic chk, wait_end, verdict;
	logic [3:0] nsrc;

	assign kind = kind_of(idx_r);
	assign sel = sel_of(idx_r);
	assign k = idx_r[1:0];

	// Sequencer next-state: drives, waits, checks and records
	always_comb
	begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		ph_nxt = ph_r;
		src_nxt = src_r;
		cnt_nxt = cnt_r;
		ok_nxt = ok_r;
		det_nxt = det_r;
		pa_o_nxt = port_a_line_o_r;
		pa_oe_n_nxt = port_a_line_oe_n_r;
		dav_nxt = buffered_data_valid_r;
		dio_oe_n_nxt = bus_dio1_oe_n_r;
		get_nxt = get_req_r;
		trig_nxt = trig_drive_all_r;
		busy_nxt = test_busy_r;
		done_nxt = test_done_r;
		pass_nxt = test_pass_r;
		fail_nxt = test_fail_r;
		chk = 1'b1;
		wait_end = 1'b0;
		verdict = ok_r;
		nsrc = 4'h0;
		unique case (st_r)
			ST_IDLE:
			begin
				// Normal use: port A lines drive the outputs, user drives triggers
				pa_o_nxt = user_dig_out;
				pa_oe_n_nxt = 4'h0;
				trig_nxt = user_trig_drive;
				dav_nxt = 1'b0;
				dio_oe_n_nxt = 1'b1;
				get_nxt = 1'b0;
				if (start)
				begin
					st_nxt = ST_APPLY;
					idx_nxt = 5'h00;
					ph_nxt = 1'b0;
					src_nxt = 3'h0;
					ok_nxt = 1'b1;
					det_nxt = 1'b0;
					busy_nxt = 1'b1;
					done_nxt = 1'b0;
					pass_nxt = '0;
					fail_nxt = '0;
				end
			end
			ST_APPLY:
			begin
				// Release everything, then drive only what this step needs
				pa_o_nxt = 4'hf;
				pa_oe_n_nxt = 4'hf;
				trig_nxt = 7'h00;
				dav_nxt = 1'b0;
				dio_oe_n_nxt = 1'b1;
				get_nxt = 1'b0;
				cnt_nxt = 16'h0000;
				st_nxt = ST_WAIT;
				unique case (kind)
					K_OUT:
					begin
						// Even tests drive lines 4,6; odd tests drive 5,7
						pa_oe_n_nxt = idx_r[0] ? 4'h5 : 4'ha;
						pa_o_nxt[k] = ~ph_r;
					end
					K_HSHK: dav_nxt = ~ph_r;
					K_DATA: dio_oe_n_nxt = ph_r;
					K_TBUS, K_XTRIG: trig_nxt = ph_r ? 7'h00 : (7'h01 << sel);
					K_GET: get_nxt = ~ph_r;
					K_SHORT:
					begin
						// Source 7 is the group execute trigger, others are drives
						if (src_r == 3'h7)
							get_nxt = ~ph_r;
						else
							trig_nxt = ph_r ? 7'h00 : (7'h01 << src_r);
					end
					default: chk = 1'b1;
				endcase
			end
			ST_WAIT:
			begin
				cnt_nxt = cnt_r + 16'h0001;
				// A low on the watched input is a trigger; latch it at once
				if (!trig_in_all[sel])
					det_nxt = 1'b1;
				if (kind == K_HSHK)
				begin
					// Acceptor accepts while valid, then is ready again after release
					chk = ph_r ? (buffered_not_data_accepted && !buffered_not_ready_for_data)
						: !buffered_not_data_accepted;
					wait_end = chk || (cnt_r >= TIMEOUT_W);
				end
				else
				begin
					wait_end = (cnt_r >= SETTLE_W);
					unique case (kind)
						K_OUT: chk = (port_a_line_i[k + 2'd1] == ~ph_r);
						K_DIGIN: chk = dig_in_port_line;
						K_DATA: chk = (bus_data_sense_line == ph_r);
						default: chk = 1'b1;
					endcase
				end
				if (wait_end)
				begin
					ok_nxt = ok_r & chk;
					st_nxt = ST_EVAL;
				end
			end
			ST_EVAL:
			begin
				nsrc = {1'b0, src_r} + 4'h1;
				if (nsrc[2:0] == sel)
					nsrc = nsrc + 4'h1;
				unique case (kind)
					K_TBUS, K_GET: verdict = det_r;
					K_XTRIG, K_SHORT: verdict = !det_r;
					default: verdict = ok_r;
				endcase
				st_nxt = ST_APPLY;
				if (!ph_r)
					ph_nxt = 1'b1;
				else if (kind == K_SHORT && !nsrc[3])
				begin
					ph_nxt = 1'b0;
					src_nxt = nsrc[2:0];
				end
				else
				begin
					pass_nxt[idx_r] = verdict;
					fail_nxt[idx_r] = !verdict;
					ph_nxt = 1'b0;
					ok_nxt = 1'b1;
					det_nxt = 1'b0;
					idx_nxt = idx_r + 5'h01;
					src_nxt = (sel_of(idx_r + 5'h01) == 3'h0) ? 3'h1 : 3'h0;
					if (idx_r == `STL_T_LAST)
					begin
						st_nxt = ST_IDLE;
						busy_nxt = 1'b0;
						done_nxt = 1'b1;
					end
				end
			end
		endcase
	end

	// Sequencer registers; open-collector outputs pull low when a line is low
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			idx_r <= 5'h00;
			ph_r <= 1'b0;
			src_r <= 3'h0;
			cnt_r <= 16'h0000;
			ok_r <= 1'b1;
			det_r <= 1'b0;
			port_a_line_o_r <= 4'hf;
			port_a_line_oe_n_r <= 4'hf;
			oc_output_o_r <= 4'h0;
			oc_output_oe_n_r <= 4'hf;
			buffered_data_valid_r <= 1'b0;
			bus_dio1_o_r <= 1'b0;
			bus_dio1_oe_n_r <= 1'b1;
			trig_drive_all_r <= 7'h00;
			get_req_r <= 1'b0;
			test_busy_r <= 1'b0;
			test_done_r <= 1'b0;
			test_pass_r <= '0;
			test_fail_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			ph_r <= ph_nxt;
			src_r <= src_nxt;
			cnt_r <= cnt_nxt;
			ok_r <= ok_nxt;
			det_r <= det_nxt;
			port_a_line_o_r <= pa_o_nxt;
			port_a_line_oe_n_r <= pa_oe_n_nxt;
			oc_output_o_r <= 4'h0;
			oc_output_oe_n_r <= pa_oe_n_nxt | pa_o_nxt;
			buffered_data_valid_r <= dav_nxt;
			bus_dio1_o_r <= 1'b0;
			bus_dio1_oe_n_r <= dio_oe_n_nxt;
			trig_drive_all_r <= trig_nxt;
			get_req_r <= get_nxt;
			test_busy_r <= busy_nxt;
			test_done_r <= done_nxt;
			test_pass_r <= pass_nxt;
			test_fail_r <= fail_nxt;
		end
	end

	// Digital input level, sampled on every clock; the protection network is external
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			dig_in_level_r <= 1'b1;
		else
			dig_in_level_r <= dig_in_port_line;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_start;
		st_r == ST_IDLE && start;
	endsequence
	sequence s_first_step;
		st_r == ST_APPLY ##1 st_r == ST_WAIT && idx_r == 5'h00;
	endsequence

	chk_start_seq: assert property (s_start |=> s_first_step ##0 test_busy_r)
		else $error("Start did not launch the first subtest");
	chk_oc_follow: assert property (oc_output_oe_n_r == (port_a_line_oe_n_r | port_a_line_o_r))
		else $error("Open-collector output does not follow its port line");
	chk_dir_even: assert property (st_r == ST_WAIT && kind == K_OUT && !idx_r[0]
		|-> port_a_line_oe_n_r == 4'ha)
		else $error("Even output test has wrong line directions");
	chk_dir_odd: assert property (st_r == ST_WAIT && kind == K_OUT && idx_r[0]
		|-> port_a_line_oe_n_r == 4'h5)
		else $error("Odd output test has wrong line directions");
	chk_out_toggle: assert property (st_r == ST_WAIT && kind == K_OUT
		|-> port_a_line_o_r[k] == !ph_r)
		else $error("Output under test not toggled");
	chk_bus_pulse: assert property (st_r == ST_WAIT && kind == K_TBUS && !ph_r
		|-> trig_drive_all_r == (7'h01 << sel) && !get_req_r)
		else $error("Trigger bus drive does not match selected input");
	chk_xtrig_invert: assert property (st_r == ST_EVAL && kind == K_XTRIG && ph_r
		|=> test_fail_r[`STL_T_XTRIG] == $past(det_r))
		else $error("External trigger verdict not inverted");
	chk_get_req: assert property (st_r == ST_WAIT && kind == K_GET
		|-> get_req_r == !ph_r && trig_drive_all_r == 7'h00)
		else $error("Group execute request wrong");
	chk_short_skip: assert property (st_r == ST_WAIT && kind == K_SHORT
		|-> src_r != sel)
		else $error("Shorts test toggles its own input");
	chk_dav_drive: assert property (st_r == ST_WAIT && kind == K_HSHK
		|-> buffered_data_valid_r == !ph_r)
		else $error("Data valid wrong during handshake");
	chk_dio_drive: assert property (st_r == ST_WAIT && kind == K_DATA
		|-> bus_dio1_oe_n_r == ph_r)
		else $error("Data line 1 drive wrong");
	chk_digin_sample: assert property (##1 dig_in_level_r == $past(dig_in_port_line))
		else $error("Digital input not sampled");
	chk_done_flag: assert property ($rose(test_done_r) |-> !test_busy_r
		&& ((test_pass_r ^ test_fail_r) == {`STL_NUM_TESTS{1'b1}}))
		else $error("Completion without a full result set");

endmodule
`default_nettype wire

// ---- testbench/stl_far_side.sv ----
// Far-side model: output return paths, input pull-up, bus acceptor, trigger bus
`timescale 1ns/1ps
`default_nettype none
module stl_far_side (
	input wire logic clk_sys,
	input wire logic [3:0] line_o,
	input wire logic [3:0] line_oe_n,
	input wire logic [3:0] oc_oe_n,
	input wire logic dav,
	input wire logic dio1_oe_n,
	input wire logic [6:0] drive,
	input wire logic get_req,
	input wire logic [4:0] knob,
	output logic [3:0] line_i,
	output logic dig_in,
	output logic nrfd,
	output logic ndac,
	output logic dio1_sense,
	output logic [7:0] trig_in
);
	logic [3:0] dav_d = 4'h0;
	logic dav_seen;
	logic [5:0] bus_low;
	// A released line reads the output wired back to it
	always_comb
	begin
		for (int j = 0; j < 4; j++)
			line_i[j] = !line_oe_n[j] ? line_o[j] : oc_oe_n[(j + 3) % 4];
	end
	// Pull-ups hold the idle input and data line high
	assign dig_in = !knob[0];
	assign dio1_sense = dio1_oe_n;
	// Acceptor answers after one or four edges; a stalled one never accepts
	always @(posedge clk_sys)
		dav_d <= {dav_d[2:0], dav};
	assign dav_seen = knob[2] ? dav_d[3] : dav_d[0];
	assign nrfd = knob[1] ? 1'b0 : dav_seen;
	assign ndac = knob[1] ? 1'b1 : !dav_seen;
	// Any party pulling down wins; a short joins lines 0 and 1
	assign bus_low = drive[5:0] | (knob[3] ? {4'h0, {2{|drive[1:0]}}} : 6'h00);
	// External input only sees channel ready through a cable short
	assign trig_in = {!get_req, !(knob[4] & drive[6]), ~bus_low};
endmodule
`default_nettype wire

// ---- testbench/stl_selftest_test.sv ----
// Self-checking bench for the I/O and trigger loopback self-test
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"
module stl_selftest_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [3:0] udo = 4'h0;
	logic [6:0] utd = 7'h00;
	logic [4:0] knob = 5'h00;
	logic [3:0] line_i, line_o, line_oe_n, oc_o, oc_oe_n;
	logic dig_in, dig_lvl, nrfd, ndac, dav, dio1_o, dio1_oe_n, dio1_sense;
	logic [6:0] drive;
	logic [7:0] trig_in;
	logic get_req, busy, done;
	logic [`STL_NUM_TESTS-1:0] pass, fail;
	logic [6:0] seen_drive = 7'h00;
	logic seen_get = 1'b0;
	int err_count = 0;
	int n_tests = 0;
	// Free-running 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	// Short counts keep each run brief
	stl_selftest #(.SETTLE_CYC(2), .TIMEOUT_CYC(10)) dut (
		.clk_sys, .rst, .start, .user_dig_out(udo), .user_trig_drive(utd),
		.port_a_line_i(line_i), .port_a_line_o_r(line_o), .port_a_line_oe_n_r(line_oe_n),
		.oc_output_o_r(oc_o), .oc_output_oe_n_r(oc_oe_n),
		.dig_in_port_line(dig_in), .dig_in_level_r(dig_lvl),
		.buffered_not_ready_for_data(nrfd), .buffered_not_data_accepted(ndac),
		.buffered_data_valid_r(dav), .bus_dio1_o_r(dio1_o), .bus_dio1_oe_n_r(dio1_oe_n),
		.bus_data_sense_line(dio1_sense), .trig_drive_all_r(drive), .trig_in_all(trig_in),
		.get_req_r(get_req), .test_busy_r(busy), .test_done_r(done),
		.test_pass_r(pass), .test_fail_r(fail)
	);
	stl_far_side far (
		.clk_sys, .line_o, .line_oe_n, .oc_oe_n, .dav, .dio1_oe_n, .drive, .get_req, .knob,
		.line_i, .dig_in, .nrfd, .ndac, .dio1_sense, .trig_in
	);
	// Remember which trigger sources were pulsed; a start taken in idle clears the record
	always @(posedge clk_sys)
	begin
		if (start && !busy)
		begin
			seen_drive <= 7'h00;
			seen_get <= 1'b0;
		end
		else
		begin
			seen_drive <= seen_drive | drive;
			seen_get <= seen_get | get_req;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string msg);
		cmp_vec({31'h0, got}, {31'h0, exp}, msg);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Reset levels, then idle pass-through of user values
	task automatic t_reset;
		rst = 1'b1;
		tick(3);
		cmp_vec(32'({line_oe_n, line_o, oc_oe_n, drive}), 32'h7ff80, "reset pins");
		cmp_vec(32'({dav, dio1_o, dio1_oe_n, get_req, busy, done, dig_lvl}), 32'h11, "reset flags");
		cmp_vec(32'(pass | fail), 32'h0, "reset results");
		rst = 1'b0;
		udo = 4'h5;
		utd = 7'h55;
		knob = 5'h01;
		tick(3);
		cmp_vec(32'({line_oe_n, line_o, oc_oe_n, oc_o}), 32'h0550, "idle lines");
		cmp_vec(32'(drive), 32'h55, "idle drives");
		cmp_bit(dig_lvl, 1'b0, "input level");
		utd = 7'h00;
		knob = 5'h00;
		tick(2);
		$display("test reset_idle done");
	endtask
	// One full run; a second start mid-run must be ignored
	task automatic run(input logic [22:0] exp_fail, input string name);
		int n;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(1);
		cmp_bit(busy, 1'b1, "busy");
		tick(2);
		cmp_vec(32'(pass | fail), 32'h0, "cleared");
		tick(18);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 4000)
		begin
			tick(1);
			n++;
		end
		cmp_bit(done, 1'b1, name);
		cmp_vec(32'(fail), 32'(exp_fail), name);
		cmp_vec(32'(pass), {9'h000, ~exp_fail}, name);
		cmp_vec(32'({seen_get, seen_drive}), 32'hff, "sources");
		tick(5);
		cmp_vec(32'({busy, done}), 32'h1, "done stands");
		$display("test %s done", name);
	endtask
	// Faulted runs first, so the clean run also shows results cleared
	initial
	begin
		t_reset;
		knob = 5'h03;
		run(23'h000030, "input_low_stall");
		knob = 5'h18;
		run(23'h01a000, "trigger_shorts");
		knob = 5'h04;
		run(23'h000000, "clean_slow");
		complete_run;
	end
	// Hang guard, well beyond three runs
	initial
	begin
		#200000;
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run;
	end
endmodule
`default_nettype wire
